// ===== cse_chop_seq.v
// global chop conversion sequencer and excitation current configuration, AXI4-Lite slave
`timescale 1ns/1ps
`include "cse_map.vh"

module cse_chop_seq (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire        conv_clk_en,
    input  wire        start_pin,
    input  wire        start_cmd_fall7,
    input  wire        reference_enabled,
    input  wire [15:0] raw_data,
    output reg         input_swap,
    output reg         conv_busy,
    output reg         conv_end,
    output reg  [15:0] result_data,
    output reg         result_ready,
    output wire [3:0]  current_magnitude_field,
    output wire [3:0]  first_current_route_field,
    output wire [3:0]  second_current_route_field,
    output wire        excitation_on
);

    // ------------------------------------------------------------
    // state codes and functions
    // ------------------------------------------------------------
    localparam ST_IDLE = 1'b0;
    localparam ST_CONV = 1'b1;

    // length of one conversion in modulator periods, before the delay
    function [19:0] half_len;
        input       low_latency;
        input [3:0] code;
        begin
            case ({low_latency, code})
                5'h10: half_len = `CSE_LL_0;
                5'h11: half_len = `CSE_LL_1;
                5'h12: half_len = `CSE_LL_2;
                5'h13: half_len = `CSE_LL_3;
                5'h14: half_len = `CSE_LL_4;
                5'h15: half_len = `CSE_LL_5;
                5'h16: half_len = `CSE_LL_6;
                5'h17: half_len = `CSE_LL_7;
                5'h18: half_len = `CSE_LL_8;
                5'h19: half_len = `CSE_LL_9;
                5'h1a: half_len = `CSE_LL_10;
                5'h1b: half_len = `CSE_LL_11;
                5'h1c: half_len = `CSE_LL_12;
                5'h1d: half_len = `CSE_LL_13;
                5'h1e: half_len = `CSE_LL_13;
                5'h1f: half_len = `CSE_LL_13;
                5'h00: half_len = `CSE_S3_0;
                5'h01: half_len = `CSE_S3_1;
                5'h02: half_len = `CSE_S3_2;
                5'h03: half_len = `CSE_S3_3;
                5'h04: half_len = `CSE_S3_4;
                5'h05: half_len = `CSE_S3_5;
                5'h06: half_len = `CSE_S3_6;
                5'h07: half_len = `CSE_S3_7;
                5'h08: half_len = `CSE_S3_8;
                5'h09: half_len = `CSE_S3_9;
                5'h0a: half_len = `CSE_S3_10;
                5'h0b: half_len = `CSE_S3_11;
                5'h0c: half_len = `CSE_S3_12;
                default: half_len = `CSE_S3_13;
            endcase
        end
    endfunction

    // settling delay in modulator periods; code 0 is the default
    function [19:0] delay_len;
        input [2:0] code;
        begin
            case (code)
                3'h0: delay_len = `CSE_DELAY_DEFAULT;
                3'h1: delay_len = 20'd4;
                3'h2: delay_len = 20'd8;
                3'h3: delay_len = 20'd16;
                3'h4: delay_len = 20'd64;
                3'h5: delay_len = 20'd256;
                3'h6: delay_len = 20'd1024;
                default: delay_len = 20'd4096;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // register file and AXI4-Lite slave
    // ------------------------------------------------------------
    reg [7:0]  gain_setting;
    reg [7:0]  data_rate;
    reg [7:0]  excitation_current_one;
    reg [7:0]  excitation_current_two;
    reg        aw_held;
    reg        w_held;
    reg [5:0]  aw_idx;
    reg [7:0]  w_byte;
    reg        w_lane0;
    reg        state;
    reg        half_valid;
    reg [15:0] half_data;
    reg [19:0] mod_cnt;
    reg [3:0]  div_cnt;
    reg        start_pin_q;

    wire       wr_fire = aw_held & w_held & ~s_axi_bvalid;
    wire       wr_map  = (aw_idx == `CSE_IDX_GAIN) | (aw_idx == `CSE_IDX_RATE) |
                         (aw_idx == `CSE_IDX_EXC_ONE) | (aw_idx == `CSE_IDX_EXC_TWO);
    wire       cfg_wr  = wr_fire & wr_map & w_lane0;
    wire [5:0] ar_idx  = s_axi_araddr[7:2];

    assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
    assign s_axi_arready = ~s_axi_rvalid;

    // write channels are latched independently, so address and data may come in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            aw_idx       <= 6'h00;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_idx  <= s_axi_awaddr[7:2];
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // configuration registers; only byte lane 0 carries data
    always @(posedge aclk) begin
        if (!aresetn) begin
            gain_setting           <= `CSE_RST_GAIN;
            data_rate              <= `CSE_RST_RATE;
            excitation_current_one <= `CSE_RST_EXC_ONE;
            excitation_current_two <= `CSE_RST_EXC_TWO;
        end else if (cfg_wr) begin
            case (aw_idx)
                `CSE_IDX_GAIN:    gain_setting <= w_byte;
                `CSE_IDX_RATE:    data_rate <= w_byte;
                `CSE_IDX_EXC_ONE: excitation_current_one <= w_byte;
                default:          excitation_current_two <= w_byte;
            endcase
        end
    end

    // read path; unmapped words read zero with a slave error
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (ar_idx)
                `CSE_IDX_GAIN:    s_axi_rdata <= {24'h000000, gain_setting};
                `CSE_IDX_RATE:    s_axi_rdata <= {24'h000000, data_rate};
                `CSE_IDX_EXC_ONE: s_axi_rdata <= {24'h000000, excitation_current_one};
                `CSE_IDX_EXC_TWO: s_axi_rdata <= {24'h000000, excitation_current_two};
                `CSE_IDX_STATUS:  s_axi_rdata <= {29'h00000000, half_valid, input_swap, conv_busy};
                `CSE_IDX_RESULT:  s_axi_rdata <= {16'h0000, result_data};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // excitation current configuration
    // ------------------------------------------------------------
    // shared magnitude field
    assign current_magnitude_field    = excitation_current_one[`CSE_MAG_HI:`CSE_MAG_LO];
    // independent routes
    // no exclusion check: both sources may name the same pin
    assign first_current_route_field  = excitation_current_two[3:0];
    assign second_current_route_field = excitation_current_two[7:4];
    assign excitation_on = reference_enabled & (current_magnitude_field != 4'h0);

    // ------------------------------------------------------------
    // conversion timing
    // ------------------------------------------------------------
    wire        chop_on   = data_rate[`CSE_CHOP_BIT];
    wire        single    = data_rate[`CSE_SINGLE_BIT];
    wire        start_hit = (start_pin & ~start_pin_q) | start_cmd_fall7;
    wire        mod_tick  = conv_clk_en & (div_cnt == 4'hf);
    wire [19:0] conv_len  = half_len(data_rate[`CSE_LOWLAT_BIT], data_rate[`CSE_RATE_HI:`CSE_RATE_LO]) +
                            delay_len(gain_setting[`CSE_DELAY_HI:`CSE_DELAY_LO]);
    wire        conv_done = (state == ST_CONV) & mod_tick & (mod_cnt >= conv_len - 20'd1);
    wire [16:0] diff      = input_swap ? ({half_data[15], half_data} - {raw_data[15], raw_data})
                                       : ({raw_data[15], raw_data} - {half_data[15], half_data});

    // modulator period is sixteen converter clocks
    // following the converter clock enable keeps all timing proportional to its rate
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_cnt     <= 4'h0;
            start_pin_q <= 1'b0;
        end else begin
            start_pin_q <= start_pin;
            if (conv_clk_en)
                div_cnt <= div_cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // chop sequencer
    // ------------------------------------------------------------
    // trigger, or config write during a conversion, restarts
    // restart discards a pending half so a stale opposite-polarity sample is never averaged
    always @(posedge aclk) begin
        if (!aresetn) begin
            state        <= ST_IDLE;
            mod_cnt      <= 20'h00000;
            input_swap   <= 1'b0;
            half_valid   <= 1'b0;
            half_data    <= 16'h0000;
            conv_busy    <= 1'b0;
            conv_end     <= 1'b0;
            result_ready <= 1'b0;
            result_data  <= 16'h0000;
        end else begin
            conv_end     <= 1'b0;
            result_ready <= 1'b0;
            if (start_hit || (cfg_wr && state == ST_CONV)) begin
                state      <= ST_CONV;
                conv_busy  <= 1'b1;
                mod_cnt    <= 20'h00000;
                input_swap <= 1'b0;
                half_valid <= 1'b0;
            end else if (cfg_wr) begin
                input_swap <= 1'b0;
                half_valid <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        conv_busy <= 1'b0;
                    end
                    ST_CONV: begin
                        if (mod_tick)
                            mod_cnt <= mod_cnt + 20'h00001;
                        if (conv_done) begin
                            mod_cnt  <= 20'h00000;
                            conv_end <= 1'b1;
                            if (!chop_on) begin
                                result_data  <= raw_data;
                                result_ready <= 1'b1;
                                if (single) begin
                                    state     <= ST_IDLE;
                                    conv_busy <= 1'b0;
                                end
                            end else begin
                                half_data  <= raw_data;
                                half_valid <= 1'b1;
                                input_swap <= ~input_swap;
                                if (half_valid) begin
                                    result_data  <= diff[16:1];
                                    result_ready <= 1'b1;
                                    if (single) begin
                                        state      <= ST_IDLE;
                                        conv_busy  <= 1'b0;
                                        half_valid <= 1'b0;
                                        input_swap <= 1'b0;
                                    end
                                end
                            end
                        end
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end

endmodule

// ===== cse_map.vh
// register map, field layout, reset values and timing counts of the chop sequencer
`ifndef CSE_MAP_VH
`define CSE_MAP_VH

// register indexes; byte address is four times the index
`define CSE_IDX_GAIN        6'h03
`define CSE_IDX_RATE        6'h04
`define CSE_IDX_EXC_ONE     6'h06
`define CSE_IDX_EXC_TWO     6'h07
`define CSE_IDX_STATUS      6'h10
`define CSE_IDX_RESULT      6'h11

// reset values
`define CSE_RST_GAIN        8'h00
`define CSE_RST_RATE        8'h0d
`define CSE_RST_EXC_ONE     8'h00
`define CSE_RST_EXC_TWO     8'hff

// field positions
`define CSE_DELAY_HI        7
`define CSE_DELAY_LO        5
`define CSE_RATE_HI         3
`define CSE_RATE_LO         0
`define CSE_CHOP_BIT        4
`define CSE_LOWLAT_BIT      5
`define CSE_SINGLE_BIT      6
`define CSE_MAG_HI          3
`define CSE_MAG_LO          0

// converter timing: counts are in modulator periods, referenced to a 4096 kHz converter clock
`define CSE_FCLK_KHZ        4096
`define CSE_MOD_DIV         16
`define CSE_DELAY_DEFAULT   20'd28

// one chopped half conversion, low-latency filter, rate codes 0..13
`define CSE_LL_0   20'd104065
`define CSE_LL_1   20'd52865
`define CSE_LL_2   20'd27265
`define CSE_LL_3   20'd15425
`define CSE_LL_4   20'd14465
`define CSE_LL_5   20'd5160
`define CSE_LL_6   20'd4329
`define CSE_LL_7   20'd2600
`define CSE_LL_8   20'd1320
`define CSE_LL_9   20'd680
`define CSE_LL_10  20'd360
`define CSE_LL_11  20'd296
`define CSE_LL_12  20'd168
`define CSE_LL_13  20'd104

// one chopped half conversion, three-stage sinc filter, rate codes 0..13
`define CSE_S3_0   20'd307265
`define CSE_S3_1   20'd153665
`define CSE_S3_2   20'd76865
`define CSE_S3_3   20'd46145
`define CSE_S3_4   20'd38465
`define CSE_S3_5   20'd15425
`define CSE_S3_6   20'd12857
`define CSE_S3_7   20'd7745
`define CSE_S3_8   20'd3905
`define CSE_S3_9   20'd1985
`define CSE_S3_10  20'd1025
`define CSE_S3_11  20'd808
`define CSE_S3_12  20'd424
`define CSE_S3_13  20'd232

`endif

// ===== cse_host_model.sv
// host controller model: start trigger pin, start command edge, converter clock and filter samples
`timescale 1ns/1ps

module cse_host_model #(
    parameter [15:0] NRM = 16'h0400,
    parameter [15:0] SWP = 16'hfe00
) (
    input  wire        aclk,
    input  wire        fire_pin,
    input  wire        fire_cmd,
    input  wire        input_swap,
    output reg         start_pin,
    output reg         start_cmd_fall7,
    output wire        conv_clk_en,
    output wire [15:0] raw_data
);
    reg [2:0] hold;

    // converter clock enable every cycle, so one modulator period is 16 cycles
    assign conv_clk_en = 1'b1;
    // sample follows the polarity the sequencer selects; a fixed offset makes averaging visible
    assign raw_data = input_swap ? SWP : NRM;

    initial begin
        start_pin = 1'b0;
        start_cmd_fall7 = 1'b0;
        hold = 3'h0;
    end

    // pin held high a few cycles, command edge is one cycle
    always @(posedge aclk) begin
        start_cmd_fall7 <= fire_cmd;
        if (fire_pin)
            hold <= 3'h4;
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
        start_pin <= fire_pin || (hold > 3'h1);
    end
endmodule

// ===== cse_chop_seq_chk.sv
// port-level assertions for the chop sequencer
`timescale 1ns/1ps

module cse_chop_seq_chk (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire        start_pin,
    input wire        start_cmd_fall7,
    input wire        reference_enabled,
    input wire        input_swap,
    input wire        conv_busy,
    input wire        conv_end,
    input wire [15:0] result_data,
    input wire        result_ready,
    input wire [3:0]  current_magnitude_field,
    input wire        excitation_on
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_write_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // a conversion is far longer than 8 cycles, so ends never bunch up
    sequence s_conv_quiet;
        !conv_end [*8];
    endsequence
    // both halves are latched at the taking edge, the response is raised one edge later
    a_write_answer: assert property (s_write_taken |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_pin_start: assert property ($rose(start_pin) |=> conv_busy && !input_swap)
        else $error("pin edge did not start normal polarity");
    a_cmd_start: assert property (start_cmd_fall7 |=> conv_busy && !input_swap)
        else $error("command did not restart normal polarity");
    a_end_spacing: assert property (conv_end |=> s_conv_quiet)
        else $error("conversion ends too close");
    a_result_update: assert property ($changed(result_data) |-> result_ready)
        else $error("result changed without ready");
    a_result_pulse: assert property (result_ready |=> !result_ready)
        else $error("result ready longer than a cycle");
    a_excite_gate: assert property (excitation_on == (reference_enabled && current_magnitude_field != 4'h0))
        else $error("excitation enable wrong");
endmodule

bind cse_chop_seq cse_chop_seq_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .start_pin(start_pin), .start_cmd_fall7(start_cmd_fall7),
    .reference_enabled(reference_enabled), .input_swap(input_swap), .conv_busy(conv_busy),
    .conv_end(conv_end), .result_data(result_data), .result_ready(result_ready),
    .current_magnitude_field(current_magnitude_field), .excitation_on(excitation_on));

// ===== tb.sv
// self-checking bench for the chop sequencer and excitation configuration
`timescale 1ns/1ps
`include "cse_map.vh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("unexpected %s expected %h seen %h", nm, ex, got); end end

module tb;
    reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    reg         fire_pin, fire_cmd, reference_enabled;
    reg  [7:0]  awaddr, araddr;
    reg  [31:0] wdata;
    reg  [3:0]  wstrb;
    wire        awready, wready, bvalid, arready, rvalid, ck_en, st_pin, st_cmd;
    wire        input_swap, conv_busy, conv_end, result_ready, excitation_on;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [15:0] raw, result_data;
    wire [3:0]  mag, route_one, route_two;
    integer     n_errors, num_checks, cyc, t;
    localparam [7:0] A_GAIN = {`CSE_IDX_GAIN, 2'b00};
    localparam [7:0] A_RATE = {`CSE_IDX_RATE, 2'b00};
    localparam [7:0] A_ONE  = {`CSE_IDX_EXC_ONE, 2'b00};
    localparam [7:0] A_TWO  = {`CSE_IDX_EXC_TWO, 2'b00};

    cse_chop_seq dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .conv_clk_en(ck_en),
        .start_pin(st_pin), .start_cmd_fall7(st_cmd), .reference_enabled(reference_enabled), .raw_data(raw),
        .input_swap(input_swap), .conv_busy(conv_busy), .conv_end(conv_end), .result_data(result_data),
        .result_ready(result_ready), .current_magnitude_field(mag), .first_current_route_field(route_one),
        .second_current_route_field(route_two), .excitation_on(excitation_on));
    cse_host_model u_host (.aclk(aclk), .fire_pin(fire_pin), .fire_cmd(fire_cmd), .input_swap(input_swap),
        .start_pin(st_pin), .start_cmd_fall7(st_cmd), .conv_clk_en(ck_en), .raw_data(raw));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task final_report;
        begin
            $display("checks %0d mismatches %0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    task bail;
        begin
            n_errors++;
            final_report;
        end
    endtask
    // address and data offered together, each released once taken
    task automatic axw(input [7:0] a, input [7:0] d, input [1:0] er);
        integer n;
        begin
            n = 0;
            @(posedge aclk);
            awaddr <= a;
            wdata <= {24'h0, d};
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            do begin
                @(posedge aclk);
                n++;
                if (awready) awvalid <= 1'b0;
                if (wready) wvalid <= 1'b0;
            end while (bvalid !== 1'b1 && n < 50);
            bready <= 1'b0;
            if (n >= 50) bail;
            `CHK("write resp", er, bresp)
        end
    endtask
    task automatic axr(input [7:0] a, input [31:0] ex, input [1:0] er);
        integer n;
        begin
            n = 0;
            @(posedge aclk);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            do begin
                @(posedge aclk);
                n++;
                if (arready) arvalid <= 1'b0;
            end while (rvalid !== 1'b1 && n < 50);
            rready <= 1'b0;
            if (n >= 50) bail;
            `CHK("read data", ex, rdata)
            `CHK("read resp", er, rresp)
        end
    endtask
    // waits for a conversion end or a result, returning the cycle it was seen
    task automatic wait_ev(input bit res, output integer tt);
        integer n;
        begin
            n = 0;
            do begin
                @(negedge aclk);
                n++;
            end while ((res ? result_ready : conv_end) !== 1'b1 && n < 20000);
            tt = cyc;
            if (n >= 20000) bail;
        end
    endtask
    task automatic fire(input bit cmd);
        begin
            @(posedge aclk);
            fire_pin <= !cmd;
            fire_cmd <= cmd;
            @(posedge aclk);
            fire_pin <= 1'b0;
            fire_cmd <= 1'b0;
        end
    endtask
    task automatic measure(input [7:0] g, input [7:0] r, input bit cmd, input integer len, input [15:0] res);
        integer t0, t1;
        begin
            axw(A_GAIN, g, 2'b00);
            axw(A_RATE, r, 2'b00);
            fire(cmd);
            wait_ev(1'b0, t0);
            repeat (2) @(negedge aclk);
            `CHK("swap after first half", r[4], input_swap)
            wait_ev(1'b0, t1);
            `CHK("conversion length", len * 16, t1 - t0)
            wait_ev(1'b1, t0);
            `CHK("result", res, result_data)
            wait_ev(1'b1, t1);
            `CHK("result spacing", len * 16, t1 - t0)
            $display("test done gain %h rate %h", g, r);
        end
    endtask

    initial begin
        n_errors = 0;
        num_checks = 0;
        cyc = 0;
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, fire_pin, fire_cmd, reference_enabled} = 8'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        wstrb = 4'hf;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        axr(A_GAIN, {24'h0, `CSE_RST_GAIN}, 2'b00);
        axr(A_RATE, {24'h0, `CSE_RST_RATE}, 2'b00);
        axr(A_ONE, {24'h0, `CSE_RST_EXC_ONE}, 2'b00);
        axr(A_TWO, {24'h0, `CSE_RST_EXC_TWO}, 2'b00);
        axr(8'h08, 32'h0, 2'b10);
        axw(8'h08, 8'h55, 2'b10);
        $display("test done reset and map");
        reference_enabled <= 1'b1;
        axw(A_ONE, 8'h05, 2'b00);
        for (int i = 0; i < 2; i++) begin
            axw(A_TWO, i ? 8'ha2 : 8'h77, 2'b00);
            @(negedge aclk);
            `CHK("route one", i ? 4'h2 : 4'h7, route_one)
            `CHK("route two", i ? 4'ha : 4'h7, route_two)
        end
        axr(A_TWO, 32'ha2, 2'b00);
        `CHK("magnitude", 4'h5, mag)
        `CHK("excitation on", 1'b1, excitation_on)
        @(posedge aclk);
        reference_enabled <= 1'b0;
        @(negedge aclk);
        `CHK("excitation off", 1'b0, excitation_on)
        $display("test done excitation");
        measure(8'h20, 8'h1d, 1'b0, 236, 16'h0300);
        measure(8'h20, 8'h3d, 1'b1, 108, 16'h0300);
        measure(8'h00, 8'h1d, 1'b0, 260, 16'h0300);
        measure(8'h20, 8'h0d, 1'b1, 236, 16'h0400);
        axw(A_RATE, 8'h1d, 2'b00);
        fire(1'b0);
        wait_ev(1'b0, t);
        fire(1'b1);
        repeat (3) @(negedge aclk);
        `CHK("swap after restart", 1'b0, input_swap)
        `CHK("busy after restart", 1'b1, conv_busy)
        axr({`CSE_IDX_STATUS, 2'b00}, 32'h0000_0001, 2'b00);
        axr({`CSE_IDX_RESULT, 2'b00}, 32'h0000_0400, 2'b00);
        $display("test done restart");
        axw(A_RATE, 8'h5d, 2'b00);
        fire(1'b1);
        wait_ev(1'b1, t);
        `CHK("single result", 16'h0300, result_data)
        repeat (2) @(negedge aclk);
        `CHK("busy after single", 1'b0, conv_busy)
        `CHK("swap after single", 1'b0, input_swap)
        $display("test done single shot");
        final_report;
    end
endmodule
